// File: gsc_full_detect.sv
// Full-charge detector over successive average-current updates.
`timescale 1ns/1ps
module gsc_full_detect (
    input wire logic core_clk,
    input wire logic rstn,
    input wire gsc_pkg::gsc_meas_t meas,
    input wire gsc_pkg::gsc_thr_t thr,
    output logic full_pulse
);
    import gsc_pkg::*;

    logic cell_voltage_hold_reg;
    logic prev_q_reg;
    logic average_current_q;
    logic cell_voltage_bad;

    // An average current qualifies when it is positive and under the minimum.
    assign average_current_q = (meas.average_current > 16'sh0000) && (meas.average_current < $signed(thr.min_charge_current));
    assign cell_voltage_bad = meas.cell_voltage_valid && (meas.cell_voltage <= thr.charge_voltage_threshold);

    // Voltage must stay high for the whole window between two updates.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cell_voltage_hold_reg <= 1'b0;
            prev_q_reg <= 1'b0;
            full_pulse <= 1'b0;
        end else begin
            full_pulse <= meas.average_current_valid && prev_q_reg && average_current_q &&
                          cell_voltage_hold_reg && !cell_voltage_bad;
            if (meas.average_current_valid) begin
                prev_q_reg <= average_current_q;
                cell_voltage_hold_reg <= !cell_voltage_bad;
            end else if (cell_voltage_bad) begin
                cell_voltage_hold_reg <= 1'b0;
            end
        end
    end

    property p_full_needs_update;
        @(posedge core_clk) disable iff (!rstn)
        full_pulse |-> $past(meas.average_current_valid) && $past(average_current_q);
    endproperty
    a_full_needs_update: assert property (p_full_needs_update)
        else $error("Full detect without a qualifying update.");
endmodule : gsc_full_detect

// File: gsc_line_host.sv
// Host-side model of the single serial line seen by the register bank.
`timescale 1ns/1ps
module gsc_line_host (
    input wire logic hold_low,
    output logic line
);
    // The line idles high through its pull-up; the host only pulls it low.
    assign line = hold_low ? 1'b0 : 1'b1;
endmodule : gsc_line_host

// File: gsc_pkg.sv
// Constants, field layouts and carrier types of the gauge status/control bank.
// How it works
// - Charge done is set when voltage stays above the charge threshold and two successive average currents are positive and below the minimum.
// - Charge done is cleared once active relative capacity is under 90 percent.
// - Active empty is set when voltage is under its threshold and cleared once active relative capacity exceeds 5 percent.
// - Standby empty is set under 10 percent standby capacity and cleared above 15 percent.
// - Capacity learn is set only when voltage falls through the active empty threshold under a heavy discharge.
// - Capacity learn is cleared by charge done, negative current, a charge write or recall, or sleep entry.
// - Capacity learn is cleared by zero charge only when that zero follows a voltage drop under the active empty threshold.
// - Undervoltage and power-on flags are set by hardware and cleared only by a host write.
// - The four measurement flags ignore host writes and change only by internal logic.
// - The control register loads its stored default after reset and a copy command stores the host-written copy.
// - Every defined control bit is readable and writable by the host.
// - With negative blanking on, small negative currents are kept out of accumulation.
// - With undervoltage sleep on, a low input voltage plus a stable line for the sleep delay enters sleep.
// - With line-low sleep on, a line held low for the sleep delay enters sleep.
// - The net-address opcode is 33h or 39h as the opcode select bit says.
// - The undervoltage threshold is 2.45 V or 4.9 V as the threshold select bit says.
package gsc_pkg;
    localparam logic [7:0] ADDR_STATUS = 8'h01;
    localparam logic [7:0] ADDR_CONTROL = 8'h60;
    localparam int BIT_CHG_DONE = 7;
    localparam int BIT_ACT_EMPTY = 6;
    localparam int BIT_STBY_EMPTY = 5;
    localparam int BIT_LEARN = 4;
    localparam int BIT_UNDERVOLT = 2;
    localparam int BIT_POWER_ON = 1;
    localparam logic [7:0] STATUS_RESET = 8'h02;
    localparam logic [7:0] CTRL_MASK = 8'hf8;
    localparam logic [7:0] OPC_NET_ADDR_0 = 8'h33;
    localparam logic [7:0] OPC_NET_ADDR_1 = 8'h39;
    localparam logic [7:0] ACTIVE_RELATIVE_CAPACITY_CHG_CLR = 8'h5a;
    localparam logic [7:0] ACTIVE_RELATIVE_CAPACITY_AE_CLR = 8'h05;
    localparam logic [7:0] STANDBY_RELATIVE_CAPACITY_SE_SET = 8'h0a;
    localparam logic [7:0] STANDBY_RELATIVE_CAPACITY_SE_CLR = 8'h0f;
    localparam int CELL_VOLTAGE_LSB_UV = 4880;
    localparam int UV_TH_LOW_MV = 2450;
    localparam int UV_TH_HIGH_MV = 4900;
    localparam logic [15:0] UV_CODE_LOW = 16'(UV_TH_LOW_MV * 1000 / CELL_VOLTAGE_LSB_UV);
    localparam logic [15:0] UV_CODE_HIGH = 16'(UV_TH_HIGH_MV * 1000 / CELL_VOLTAGE_LSB_UV);
    localparam int CURRENT_LSB_NV = 1563;
    localparam int NEG_BLANK_UV = 25;
    localparam logic [15:0] NEG_BLANK_CODE = 16'(NEG_BLANK_UV * 1000 / CURRENT_LSB_NV);
    localparam int CLK_MHZ = 250;
    localparam int SLEEP_DELAY_US = 2000;
    localparam int SLEEP_DELAY_CYC = SLEEP_DELAY_US * CLK_MHZ;

    // One set of measurement results with their update strobes.
    typedef struct packed {
        logic [15:0] cell_voltage;
        logic cell_voltage_valid;
        logic signed [15:0] current;
        logic current_valid;
        logic signed [15:0] average_current;
        logic average_current_valid;
        logic [7:0] active_relative_capacity;
        logic [7:0] standby_relative_capacity;
        logic [15:0] input_voltage;
    } gsc_meas_t;

    // Stored thresholds from parameter memory.
    typedef struct packed {
        logic [15:0] charge_voltage_threshold;
        logic [15:0] min_charge_current;
        logic [15:0] active_empty_voltage;
        logic [15:0] active_empty_current;
    } gsc_thr_t;

    // Control register layout, bit 7 first.
    typedef struct packed {
        logic neg_blank_enable;
        logic undervolt_sleep_enable;
        logic line_low_sleep_enable;
        logic net_addr_opcode_select;
        logic undervolt_threshold_select;
        logic [2:0] rsvd;
    } gsc_ctrl_t;
endpackage : gsc_pkg

// File: gsc_regs.sv
// Status and control register bank of the fuel gauge.
`timescale 1ns/1ps
module gsc_regs #(
    parameter int SLEEP_DELAY_CYCLES = gsc_pkg::SLEEP_DELAY_CYC
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire gsc_pkg::gsc_meas_t meas,
    input wire gsc_pkg::gsc_thr_t thr,
    input wire logic acr_zero,
    input wire logic acr_touched,
    input wire logic line_in,
    input wire logic [7:0] nv_ctrl_default,
    input wire logic copy_cmd,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic [7:0] status_out,
    output gsc_pkg::gsc_ctrl_t ctrl_out,
    output logic [7:0] net_addr_opcode,
    output logic [15:0] undervolt_code,
    output logic signed [15:0] accum_current,
    output logic accum_valid,
    output logic nv_store_valid,
    output logic [7:0] nv_store_data,
    output logic sleep_active
);
    import gsc_pkg::*;

    logic [7:0] status_reg;
    logic [7:0] status_next;
    gsc_ctrl_t ctrl_reg;
    logic ctrl_loaded_reg;
    logic vae_above_reg;
    logic heavy1_reg;
    logic heavy2_reg;
    logic ae_seen_reg;
    logic full_pulse;
    logic sleep_enter;
    logic vin_low;
    logic heavy_now;
    logic learn_set;
    logic learn_clr;
    logic wr_status;
    logic wr_ctrl;
    logic neg_small;

    assign wr_status = reg_wr && (reg_addr == ADDR_STATUS);
    assign wr_ctrl = reg_wr && (reg_addr == ADDR_CONTROL);

    // Threshold chosen by the select bit.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            undervolt_code <= UV_CODE_LOW;
        end else begin
            undervolt_code <= ctrl_reg.undervolt_threshold_select ?
                              UV_CODE_HIGH : UV_CODE_LOW;
        end
    end

    assign vin_low = meas.input_voltage < undervolt_code;

    gsc_full_detect u_full (
        .core_clk(core_clk),
        .rstn(rstn),
        .meas(meas),
        .thr(thr),
        .full_pulse(full_pulse)
    );

    gsc_sleep_ctl #(
        .DELAY_CYC(SLEEP_DELAY_CYCLES)
    ) u_sleep (
        .core_clk(core_clk),
        .rstn(rstn),
        .line_in(line_in),
        .uv_en(ctrl_reg.undervolt_sleep_enable),
        .low_en(ctrl_reg.line_low_sleep_enable),
        .vin_low(vin_low),
        .sleep_enter(sleep_enter),
        .sleep_active(sleep_active)
    );

    // A reading counts as heavy discharge when it is more negative than the limit.
    assign heavy_now = meas.current < -$signed(thr.active_empty_current);

    // Track the voltage side of the active empty point and the last two currents.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            vae_above_reg <= 1'b0;
            heavy1_reg <= 1'b0;
            heavy2_reg <= 1'b0;
        end else begin
            if (meas.cell_voltage_valid) begin
                vae_above_reg <= meas.cell_voltage >= thr.active_empty_voltage;
            end
            if (meas.current_valid) begin
                heavy1_reg <= heavy_now;
                heavy2_reg <= heavy1_reg;
            end
        end
    end

    // Remember a drop under the active empty voltage until charge completes or a charge write or recall.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ae_seen_reg <= 1'b0;
        end else if (meas.cell_voltage_valid && (meas.cell_voltage < thr.active_empty_voltage)) begin
            ae_seen_reg <= 1'b1;
        end else if (full_pulse || acr_touched) begin
            ae_seen_reg <= 1'b0;
        end
    end

    assign learn_set = meas.cell_voltage_valid && vae_above_reg &&
                       (meas.cell_voltage < thr.active_empty_voltage) &&
                       heavy1_reg && heavy2_reg;
    assign learn_clr = full_pulse || status_reg[BIT_CHG_DONE] ||
                       (meas.current_valid && meas.current < 16'sh0000) ||
                       acr_touched || sleep_enter ||
                       (acr_zero && ae_seen_reg);

    // Next status value; hardware sets win over every clear, except that a full detect blocks the learn set.
    always_comb begin
        status_next = status_reg;
        if (meas.active_relative_capacity < ACTIVE_RELATIVE_CAPACITY_CHG_CLR) begin
            status_next[BIT_CHG_DONE] = 1'b0;
        end
        if (full_pulse) begin
            status_next[BIT_CHG_DONE] = 1'b1;
        end
        if (meas.active_relative_capacity > ACTIVE_RELATIVE_CAPACITY_AE_CLR) begin
            status_next[BIT_ACT_EMPTY] = 1'b0;
        end
        if (meas.cell_voltage_valid && (meas.cell_voltage < thr.active_empty_voltage)) begin
            status_next[BIT_ACT_EMPTY] = 1'b1;
        end
        if (meas.standby_relative_capacity > STANDBY_RELATIVE_CAPACITY_SE_CLR) begin
            status_next[BIT_STBY_EMPTY] = 1'b0;
        end else if (meas.standby_relative_capacity < STANDBY_RELATIVE_CAPACITY_SE_SET) begin
            status_next[BIT_STBY_EMPTY] = 1'b1;
        end
        if (learn_clr) begin
            status_next[BIT_LEARN] = 1'b0;
        end
        if (learn_set && !full_pulse) begin
            status_next[BIT_LEARN] = 1'b1;
        end
        // Host may only clear the two host bits; other bits ignore writes.
        if (wr_status) begin
            status_next[BIT_UNDERVOLT] = status_reg[BIT_UNDERVOLT] &
                                         reg_wdata[BIT_UNDERVOLT];
            status_next[BIT_POWER_ON] = status_reg[BIT_POWER_ON] &
                                        reg_wdata[BIT_POWER_ON];
        end
        if (meas.cell_voltage_valid && (meas.cell_voltage < undervolt_code)) begin
            status_next[BIT_UNDERVOLT] = 1'b1;
        end
        status_next[3] = 1'b0;
        status_next[0] = 1'b0;
    end

    // Status register; power-on flag comes up set.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            status_reg <= STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // Control register loads its stored default once after reset.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ctrl_reg <= '0;
            ctrl_loaded_reg <= 1'b0;
        end else if (!ctrl_loaded_reg) begin
            ctrl_reg <= nv_ctrl_default & CTRL_MASK;
            ctrl_loaded_reg <= 1'b1;
        end else if (wr_ctrl) begin
            ctrl_reg <= reg_wdata & CTRL_MASK;
        end
    end

    // Copy command stores the shadow copy as the new default.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            nv_store_valid <= 1'b0;
            nv_store_data <= 8'h00;
        end else begin
            nv_store_valid <= copy_cmd && ctrl_loaded_reg;
            if (copy_cmd && ctrl_loaded_reg) begin
                nv_store_data <= ctrl_reg;
            end
        end
    end

    // Register read port; unmapped addresses read zero.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    ADDR_STATUS: reg_rdata <= status_reg;
                    ADDR_CONTROL: reg_rdata <= ctrl_reg;
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Decoded control outputs for the rest of the device.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            status_out <= STATUS_RESET;
            ctrl_out <= '0;
            net_addr_opcode <= OPC_NET_ADDR_0;
        end else begin
            status_out <= status_reg;
            ctrl_out <= ctrl_reg;
            net_addr_opcode <= ctrl_reg.net_addr_opcode_select ?
                               OPC_NET_ADDR_1 : OPC_NET_ADDR_0;
        end
    end

    assign neg_small = (meas.current < 16'sh0000) &&
                       (meas.current >= -$signed(NEG_BLANK_CODE));

    // Accumulation feed with optional blanking of small negative readings.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            accum_current <= 16'sh0000;
            accum_valid <= 1'b0;
        end else begin
            accum_valid <= meas.current_valid;
            if (meas.current_valid) begin
                accum_current <= (ctrl_reg.neg_blank_enable && neg_small) ?
                                 16'sh0000 : meas.current;
            end
        end
    end

    property p_chg_clear;
        @(posedge core_clk) disable iff (!rstn)
        (meas.active_relative_capacity < ACTIVE_RELATIVE_CAPACITY_CHG_CLR) && !full_pulse
            |=> !status_reg[BIT_CHG_DONE];
    endproperty
    a_chg_clear: assert property (p_chg_clear)
        else $error("Charge done not cleared at low capacity.");

    property p_ae_set;
        @(posedge core_clk) disable iff (!rstn)
        meas.cell_voltage_valid && (meas.cell_voltage < thr.active_empty_voltage) |=> status_reg[BIT_ACT_EMPTY];
    endproperty
    a_ae_set: assert property (p_ae_set)
        else $error("Active empty not set on low voltage.");

    property p_se_hyst;
        @(posedge core_clk) disable iff (!rstn)
        (meas.standby_relative_capacity >= STANDBY_RELATIVE_CAPACITY_SE_SET) && (meas.standby_relative_capacity <= STANDBY_RELATIVE_CAPACITY_SE_CLR)
            |=> status_reg[BIT_STBY_EMPTY] == $past(status_reg[BIT_STBY_EMPTY]);
    endproperty
    a_se_hyst: assert property (p_se_hyst)
        else $error("Standby empty moved inside the hysteresis band.");

    property p_learn_rise;
        @(posedge core_clk) disable iff (!rstn)
        $rose(status_reg[BIT_LEARN]) |-> $past(learn_set);
    endproperty
    a_learn_rise: assert property (p_learn_rise)
        else $error("Learn flag rose without a qualified crossing.");

    property p_learn_clear;
        @(posedge core_clk) disable iff (!rstn)
        (sleep_enter || acr_touched) && !learn_set |=> !status_reg[BIT_LEARN];
    endproperty
    a_learn_clear: assert property (p_learn_clear)
        else $error("Learn flag survived a clearing event.");

    property p_power_on_flag_hold;
        @(posedge core_clk) disable iff (!rstn)
        status_reg[BIT_POWER_ON] && !wr_status |=> status_reg[BIT_POWER_ON];
    endproperty
    a_power_on_flag_hold: assert property (p_power_on_flag_hold)
        else $error("Power-on flag cleared without a host write.");

    // With no hardware event on a read-only flag, a host write must leave it alone.
    property p_ro_write;
        @(posedge core_clk) disable iff (!rstn)
        wr_status && !full_pulse && !learn_set && !learn_clr &&
        !meas.cell_voltage_valid &&
        ((meas.active_relative_capacity >= ACTIVE_RELATIVE_CAPACITY_CHG_CLR) || !status_reg[BIT_CHG_DONE]) &&
        ((meas.active_relative_capacity <= ACTIVE_RELATIVE_CAPACITY_AE_CLR) || !status_reg[BIT_ACT_EMPTY]) &&
        ((meas.standby_relative_capacity >= STANDBY_RELATIVE_CAPACITY_SE_SET) || status_reg[BIT_STBY_EMPTY]) &&
        ((meas.standby_relative_capacity <= STANDBY_RELATIVE_CAPACITY_SE_CLR) || !status_reg[BIT_STBY_EMPTY])
            |=> status_reg[7:4] == $past(status_reg[7:4]);
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("Host write changed a read-only flag.");

    property p_ctrl_rw;
        @(posedge core_clk) disable iff (!rstn)
        wr_ctrl && ctrl_loaded_reg
            |=> ctrl_reg == ($past(reg_wdata) & CTRL_MASK);
    endproperty
    a_ctrl_rw: assert property (p_ctrl_rw)
        else $error("Control register differs from the written value.");

    property p_ctrl_read;
        @(posedge core_clk) disable iff (!rstn)
        reg_rd && (reg_addr == ADDR_CONTROL)
            |=> reg_rvalid && (reg_rdata == $past(ctrl_reg));
    endproperty
    a_ctrl_read: assert property (p_ctrl_read)
        else $error("Control readback differs from the register.");

    property p_uv_set;
        @(posedge core_clk) disable iff (!rstn)
        meas.cell_voltage_valid && (meas.cell_voltage < undervolt_code)
            |=> status_reg[BIT_UNDERVOLT];
    endproperty
    a_uv_set: assert property (p_uv_set)
        else $error("Undervoltage flag not set on a low voltage sample.");

    property p_opcode;
        @(posedge core_clk) disable iff (!rstn)
        ##1 net_addr_opcode == ($past(ctrl_reg.net_addr_opcode_select) ?
                                OPC_NET_ADDR_1 : OPC_NET_ADDR_0);
    endproperty
    a_opcode: assert property (p_opcode)
        else $error("Net-address opcode does not follow its select bit.");

    property p_blank;
        @(posedge core_clk) disable iff (!rstn)
        meas.current_valid && ctrl_reg.neg_blank_enable && neg_small
            |=> accum_valid && accum_current == 16'sh0000;
    endproperty
    a_blank: assert property (p_blank)
        else $error("Small negative current was not blanked.");
endmodule : gsc_regs

// File: gsc_regs_tb.sv
// Self-checking testbench of the gauge status and control register bank.
`timescale 1ns/1ps
module gsc_regs_tb;
    import gsc_pkg::*;
    localparam int SLP = 20;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    gsc_meas_t m;
    gsc_thr_t t;
    logic copy_cmd = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic hold_low = 1'b0;
    logic acr_zero = 1'b0;
    logic acr_touched = 1'b0;
    logic line;
    logic [7:0] reg_rdata, status_out, net_addr_opcode, nv_store_data;
    gsc_ctrl_t ctrl_out;
    logic [15:0] undervolt_code;
    logic signed [15:0] accum_current;
    logic reg_rvalid, accum_valid, nv_store_valid, sleep_active;
    int error_cnt = 0;
    int checks = 0;

    // The clock toggles every 2 ns, a period of 4 ns.
    always #2 core_clk = ~core_clk;

    gsc_line_host host (.hold_low(hold_low), .line(line));

    gsc_regs #(.SLEEP_DELAY_CYCLES(SLP)) dut (
        .core_clk(core_clk), .rstn(rstn), .meas(m), .thr(t),
        .acr_zero(acr_zero), .acr_touched(acr_touched), .line_in(line),
        .nv_ctrl_default(8'h97), .copy_cmd(copy_cmd),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .status_out(status_out), .ctrl_out(ctrl_out),
        .net_addr_opcode(net_addr_opcode),
        .undervolt_code(undervolt_code), .accum_current(accum_current),
        .accum_valid(accum_valid), .nv_store_valid(nv_store_valid),
        .nv_store_data(nv_store_data), .sleep_active(sleep_active)
    );

    task automatic finish_test;
        if (error_cnt == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        tick(2);
    endtask : wr

    // A read is taken on one edge and answered in the following cycle.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        chk({15'h0000, reg_rvalid}, 16'h0001);
        chk({8'h00, reg_rdata}, {8'h00, exp});
        tick(1);
    endtask : rd

    task automatic vsamp(input logic [15:0] v);
        m.cell_voltage = v;
        m.cell_voltage_valid = 1'b1;
        tick(1);
        m.cell_voltage_valid = 1'b0;
        tick(2);
    endtask : vsamp

    // A current sample also shows its accumulated value one cycle later.
    task automatic isamp(input logic [15:0] c, input logic [15:0] e);
        m.current = c;
        m.current_valid = 1'b1;
        tick(1);
        m.current_valid = 1'b0;
        chk({15'h0000, accum_valid}, 16'h0001);
        chk(accum_current, e);
        tick(2);
    endtask : isamp

    task automatic avg;
        m.average_current_valid = 1'b1;
        tick(1);
        m.average_current_valid = 1'b0;
        tick(1);
    endtask : avg

    // Watchdog cuts a hang short well beyond the expected run length.
    initial begin
        #20000;
        error_cnt++;
        finish_test();
    end

    // Main sequence of register accesses and measurement events.
    initial begin
        m = '0;
        m.cell_voltage = 16'h02bc;
        m.active_relative_capacity = 8'h32;
        m.standby_relative_capacity = 8'h32;
        m.input_voltage = 16'h0384;
        t = {16'h0320, 16'h0064, 16'h0258, 16'h0032};
        tick(8);
        rstn = 1'b1;
        tick(2);
        rd(ADDR_STATUS, STATUS_RESET);
        rd(ADDR_CONTROL, 8'h90);
        chk({8'h00, net_addr_opcode}, {8'h00, OPC_NET_ADDR_1});
        wr(ADDR_CONTROL, 8'h0f);
        rd(ADDR_CONTROL, 8'h08);
        chk(undervolt_code, UV_CODE_HIGH);
        chk({8'h00, net_addr_opcode}, {8'h00, OPC_NET_ADDR_0});
        copy_cmd = 1'b1;
        tick(1);
        copy_cmd = 1'b0;
        chk({15'h0000, nv_store_valid}, 16'h0001);
        chk({8'h00, nv_store_data}, 16'h0008);
        wr(ADDR_CONTROL, 8'h87);
        rd(ADDR_CONTROL, 8'h80);
        chk({8'h00, ctrl_out}, 16'h0080);
        chk(undervolt_code, UV_CODE_LOW);
        wr(ADDR_STATUS, 8'hfd);
        rd(ADDR_STATUS, 8'h00);
        rd(8'h02, 8'h00);
        m.standby_relative_capacity = 8'h09;
        tick(3);
        chk({8'h00, status_out}, 16'h0020);
        m.standby_relative_capacity = 8'h0c;
        tick(3);
        chk({8'h00, status_out}, 16'h0020);
        m.standby_relative_capacity = 8'h10;
        tick(3);
        chk({8'h00, status_out}, 16'h0000);
        isamp(16'hfff6, 16'h0000);
        isamp(16'hffec, 16'hffec);
        wr(ADDR_CONTROL, 8'h00);
        isamp(16'hfff6, 16'hfff6);
        isamp(16'hff9c, 16'hff9c);
        isamp(16'hff9c, 16'hff9c);
        vsamp(16'h02bc);
        m.active_relative_capacity = 8'h03;
        vsamp(16'h0226);
        chk({8'h00, status_out}, 16'h0050);
        wr(ADDR_STATUS, 8'h00);
        chk({8'h00, status_out}, 16'h0050);
        isamp(16'hff9c, 16'hff9c);
        chk({8'h00, status_out}, 16'h0040);
        vsamp(16'h02bc);
        m.active_relative_capacity = 8'h06;
        tick(3);
        chk({8'h00, status_out}, 16'h0000);
        vsamp(16'h0226);
        chk({8'h00, status_out}, 16'h0010);
        acr_zero = 1'b1;
        tick(3);
        chk({8'h00, status_out}, 16'h0000);
        acr_zero = 1'b0;
        vsamp(16'h02bc);
        vsamp(16'h0226);
        chk({8'h00, status_out}, 16'h0010);
        acr_touched = 1'b1;
        tick(1);
        acr_touched = 1'b0;
        tick(2);
        chk({8'h00, status_out}, 16'h0000);
        m.active_relative_capacity = 8'h5f;
        vsamp(16'h0384);
        m.average_current = 16'h0032;
        avg();
        avg();
        tick(2);
        chk({8'h00, status_out}, 16'h0080);
        m.active_relative_capacity = 8'h50;
        tick(3);
        chk({8'h00, status_out}, 16'h0000);
        wr(ADDR_CONTROL, 8'h08);
        vsamp(16'h0384);
        chk({8'h00, status_out}, 16'h0004);
        wr(ADDR_STATUS, 8'h00);
        chk({8'h00, status_out}, 16'h0000);
        hold_low = 1'b1;
        tick(SLP + 8);
        chk({15'h0000, sleep_active}, 16'h0000);
        wr(ADDR_CONTROL, 8'h20);
        tick(SLP + 8);
        chk({15'h0000, sleep_active}, 16'h0001);
        hold_low = 1'b0;
        tick(6);
        chk({15'h0000, sleep_active}, 16'h0000);
        wr(ADDR_CONTROL, 8'h40);
        m.input_voltage = 16'h0190;
        tick(SLP + 8);
        chk({15'h0000, sleep_active}, 16'h0001);
        finish_test();
    end
endmodule : gsc_regs_tb

// File: gsc_sleep_ctl.sv
// Sleep entry timer watching the serial line and input voltage.
`timescale 1ns/1ps
module gsc_sleep_ctl #(
    parameter int DELAY_CYC = gsc_pkg::SLEEP_DELAY_CYC
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic line_in,
    input wire logic uv_en,
    input wire logic low_en,
    input wire logic vin_low,
    output logic sleep_enter,
    output logic sleep_active
);
    import gsc_pkg::*;

    localparam int CW = $clog2(DELAY_CYC + 1);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    logic [CW-1:0] cnt_reg;
    logic level_chg;
    logic cond;

    // Three-stage synchroniser; the level moves once stages two and three agree.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            level_reg <= 1'b1;
        end else begin
            s1_reg <= line_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                level_reg <= s3_reg;
            end
        end
    end

    assign level_chg = (s2_reg == s3_reg) && (s3_reg != level_reg);
    assign cond = (uv_en && vin_low) || (low_en && !level_reg);

    // Count a stable line; any line change restarts the delay.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cnt_reg <= '0;
            sleep_enter <= 1'b0;
            sleep_active <= 1'b0;
        end else begin
            sleep_enter <= 1'b0;
            if (level_chg || !cond || sleep_active) begin
                cnt_reg <= '0;
            end else if (cnt_reg == CW'(DELAY_CYC - 1)) begin
                cnt_reg <= '0;
                sleep_enter <= 1'b1;
                sleep_active <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
            if (sleep_active && level_chg) begin
                sleep_active <= 1'b0;
            end
        end
    end

    property p_sleep_needs_cond;
        @(posedge core_clk) disable iff (!rstn)
        sleep_enter |-> $past(cond) && !$past(level_chg);
    endproperty
    a_sleep_needs_cond: assert property (p_sleep_needs_cond)
        else $error("Sleep entered without an enabled condition.");
endmodule : gsc_sleep_ctl
